/* File: adc_cal_pkg.sv */
// Constants for the converter filter and calibration control block.
// Assumes a 40 MHz system clock and a 32-bit APB register bus.
package adc_cal_pkg;
  // ----------------------------------------------------------------
  // Clocking
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ    = 40_000_000;
  localparam int MOD_HZ_NORMAL = 512_000;
  localparam int MOD_HZ_LOWPWR = 131_000;
  localparam int DIV_W         = 9;
  // Longest whole period whose rate does not fall below the target rate
  localparam logic [DIV_W-1:0] MOD_DIV_NORMAL = DIV_W'(SYS_CLK_HZ / MOD_HZ_NORMAL);
  localparam logic [DIV_W-1:0] MOD_DIV_LOWPWR = DIV_W'(SYS_CLK_HZ / MOD_HZ_LOWPWR);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FILTER_OFS  = 8'h00;
  localparam logic [7:0] MODE_OFS    = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h08;
  localparam logic [7:0] RESULT_OFS  = 8'h0C;
  localparam logic [7:0] OFFSET_BASE = 8'h10;
  localparam logic [7:0] GAIN_BASE   = 8'h20;
  localparam logic [7:0] BANK_MASK   = 8'hF0;
  localparam int MAX_CH = 4;
  localparam int CH_W   = 2;
  localparam int CH_LSB = 2;

  // Filter configuration fields
  localparam int CHOP_BIT   = 15;
  localparam int RUNAVG_BIT = 14;
  localparam int AF_HI      = 13;
  localparam int AF_LO      = 8;
  localparam int MODIFY_BIT = 7;
  localparam int SF_HI      = 6;
  localparam int SF_LO      = 0;
  localparam logic [15:0] FILTER_RESET = 16'h0007;

  // Mode register fields
  localparam int MODE_W      = 10;
  localparam int MODE_HI     = 2;
  localparam int LP_BIT      = 3;
  localparam int OFFBIN_BIT  = 4;
  localparam int CH_HI       = 9;
  localparam int CH_LO       = 8;
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h000;

  // Status fields
  localparam int ST_DONE_BIT = 0;
  localparam int ST_CAL_BIT  = 1;
  localparam int ST_ACT_BIT  = 2;

  typedef enum logic [2:0] {
    md_off       = 3'b000,
    md_cont      = 3'b001,
    md_single    = 3'b010,
    md_idle      = 3'b011,
    md_self_off  = 3'b100,
    md_self_gain = 3'b101,
    md_sys_off   = 3'b110,
    md_sys_gain  = 3'b111
  } conv_mode_e;

  typedef enum logic [1:0] {
    src_ext  = 2'b00,
    src_zero = 2'b01,
    src_full = 2'b10
  } cal_src_e;

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  localparam logic [1:0] CAL_PASSES_CHOP  = 2'h2;
  localparam logic [1:0] CAL_PASSES_PLAIN = 2'h3;
  localparam int PROD_W     = 42;
  localparam int GAIN_FRAC  = 14;
  localparam int ROUND_BITS = 8;
  localparam logic signed [PROD_W-1:0] ROUND_HALF = 42'sh000_0000_0080;
  localparam logic signed [PROD_W-1:0] POS_LIM    = 42'sh000_0000_7FFF;
  localparam logic signed [PROD_W-1:0] NEG_LIM    = -42'sh000_0000_8000;
  localparam logic [15:0] POS_FS       = 16'h7FFF;
  localparam logic [15:0] NEG_FS       = 16'h8000;
  localparam logic [15:0] GAIN_NOMINAL = 16'h5555;
  localparam logic [15:0] GAIN_MAX     = 16'hFFFF;
  localparam logic [31:0] GAIN_CAL_NUM = 32'h1FFF_C000;
endpackage

/* File: adc_filter_and_calibration_tb_top.sv */
// Self-checking bench: APB register master plus front-end model.
// Assumes zero-wait APB and a 40 MHz clock.
`timescale 1ns/10ps
module adc_filter_and_calibration_tb_top
  import adc_cal_pkg::*;
;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr, fire;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r, seed, miscompares, check_count, cyc;
  logic        err, filter_valid, chop_en, result_valid, ravg, smod, lp, tick, act;
  logic [23:0] filter_data, ext_level, x;
  logic [15:0] result_data, v, off;
  logic [6:0]  decimation_factor;
  logic [5:0]  averaging_factor;
  logic [1:0]  cal_src_sel;

  adc_filter_cal DUT (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .filter_valid(filter_valid), .filter_data(filter_data), .chop_en(chop_en), .running_avg_en(ravg),
    .sinc_modify_en(smod), .decimation_factor(decimation_factor), .averaging_factor(averaging_factor),
    .lp_mode(lp), .mod_clk_tick(tick), .cal_src_sel(cal_src_sel), .conv_active(act),
    .result_data(result_data), .result_valid(result_valid));
  adc_front_model FE (.sys_clk(sys_clk), .rst(rst), .fire(fire), .cal_src_sel(cal_src_sel),
    .ext_level(ext_level), .filter_valid(filter_valid), .filter_data(filter_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Offset, gain/16384, round, clamp
  function automatic logic [15:0] exp_res(input logic signed [23:0] s, input logic signed [15:0] o);
    logic signed [PROD_W-1:0] p;
    p = 42'(s) - (42'(o) <<< 8);
    p = (p * $signed({26'h000_0000, GAIN_NOMINAL})) >>> GAIN_FRAC;
    p = (p + ROUND_HALF) >>> ROUND_BITS;
    if (p > POS_LIM) return POS_FS;
    if (p < NEG_LIM) return NEG_FS;
    return p[15:0];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic sample(input logic [23:0] s);
    ext_level <= s;
    fire      <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    repeat (10) begin
      @(posedge sys_clk);
      if (result_valid === 1'b1) break;
    end
  endtask
  task automatic cal_run(input logic [31:0] md, input int n, input logic [23:0] lvl);
    apb(1'b1, MODE_OFS, md);
    repeat (n - 1) sample(lvl);
    apb(1'b0, MODE_OFS, 32'h0000_0000);
    chk({act, rd[2:0]}, {1'b1, md[2:0]}); // Still busy one sample short
    sample(lvl);
    repeat (20) begin
      apb(1'b0, MODE_OFS, 32'h0000_0000);
      if (rd[2:0] === 3'h3) break;
    end
    chk({act, rd[2:0]}, 32'h0000_0003);
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, reset, watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares = miscompares + 1;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, fire} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_level = 24'h00_0000;
    seed = 32'h0000_67C3;
    miscompares = 0;
    check_count = 0;
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, OFFSET_BASE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, GAIN_BASE, 32'h0000_0000);
    chk(rd, {16'h0000, GAIN_NOMINAL});
    for (int i = 0; i < 4; i++) begin
      r = xs();
      v = (i == 0) ? 16'hBF1D : r[15:0];
      apb(1'b1, FILTER_OFS, {16'h0000, v});
      chk({chop_en, ravg, averaging_factor, smod, decimation_factor}, {16'h0000, v});
      apb(1'b0, FILTER_OFS, 32'h0000_0000);
      chk(rd, {16'h0000, v});
    end
    apb(1'b1, OFFSET_BASE, 32'h0000_1234);
    chk(err, 32'h0000_0001); // Converter off, write refused
    apb(1'b0, OFFSET_BASE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk(err, 32'h0000_0001);
    apb(1'b1, FILTER_OFS, 32'h0000_0007);
    apb(1'b1, MODE_OFS, 32'h0000_0003);
    r = xs();
    off = {8'h00, r[7:0]};
    apb(1'b1, OFFSET_BASE, {16'h0000, off});
    chk(err, 32'h0000_0000); // Idle, write taken
    apb(1'b0, OFFSET_BASE, 32'h0000_0000);
    chk(rd, {16'h0000, off});
    for (int i = 0; i < 5; i++) begin
      r = xs();
      x = (i == 0) ? 24'h7F_FFFF : (i == 1) ? 24'h80_0000 : r[23:0];
      apb(1'b1, MODE_OFS, 32'h0000_0002);
      sample(x);
      chk(result_data, exp_res(x, off));
    end
    apb(1'b1, FILTER_OFS, 32'h0000_8028);
    apb(1'b1, MODE_OFS, 32'h0000_0002);
    sample(24'h12_3456);
    sample(24'h32_1000);
    chk(result_data, exp_res(24'h22_222B, off)); // Chopped pair averaged
    apb(1'b1, FILTER_OFS, 32'h0000_0028);
    apb(1'b1, OFFSET_BASE, 32'h0000_0000); // Unity values first
    apb(1'b1, MODE_OFS, 32'h0000_0001);
    cal_run(32'h0000_0004, 3, 24'h00_0000); // Aborts the running conversion
    apb(1'b0, OFFSET_BASE, 32'h0000_0000);
    chk(rd, {16'h0000, FE.ZERO_RAW[23:8]});
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rd[ST_DONE_BIT], 32'h0000_0001);
    cal_run(32'h0000_0005, 6, 24'h00_0000);
    apb(1'b0, GAIN_BASE, 32'h0000_0000);
    chk(rd, GAIN_CAL_NUM / 32'h0000_5FCC);
    cal_run(32'h0000_0006, 3, 24'h00_1200); // Zero input first
    apb(1'b0, OFFSET_BASE, 32'h0000_0000);
    chk(rd, 32'h0000_0012);
    cal_run(32'h0000_0007, 6, 24'h50_0000); // Span above 40%
    apb(1'b0, GAIN_BASE, 32'h0000_0000);
    chk(rd, GAIN_CAL_NUM / 32'h0000_4FEE);
    apb(1'b1, MODE_OFS, 32'h0000_0009);
    chk(lp, 32'h0000_0001);
    do @(posedge sys_clk); while (tick !== 1'b1);
    cyc = 0;
    do begin
      @(posedge sys_clk);
      cyc = cyc + 1;
    end while (tick !== 1'b1);
    chk(cyc, SYS_CLK_HZ / MOD_HZ_LOWPWR);
    give_verdict();
  end
endmodule // adc_filter_and_calibration_tb_top

/* File: adc_filter_cal.sv */
// Filter configuration, result path and calibration sequencer.
// Assumes an external decimator delivering one signed fraction per strobe.
`timescale 1ns/10ps
// What this block does or relies on
// [R01] Chop bit 15, decimation 6:0, averaging 13:8
// [R02] Chop, 0x1D/0x3F gives slowest 4 Hz
// [R03] Low power clocks modulator at 131 kHz
// [R04] Low power, 0xBD1F gives 1 Hz
// [R05] Listed configurations give listed rates
// [R06] Software picks decimation 0x10..0x28 first
// [R07] Chop average, offset, gain, round, clamp, format
// [R08] Per-channel coefficients loaded with factory values
// [R09] Coefficient writes only while idle
// [R10] Calibration overwrites offset or gain coefficient
// [R11] Self calibration measures internal zero/full-scale
// [R12] Outside holds system level during calibration
// [R13] Offset calibration: three periods, two chopped
// [R14] Gain calibration: two stages, twice long
// [R15] Calibration aborts conversion, ends in idle
// [R16] Software calibrates at slow rates
// [R17] Software preloads unity coefficients before calibrating
// [R18] System span exceeds 40% full scale
// [R19] Zero-scale then full-scale system calibration
// [R20] Signed offset subtracted from filter output
// [R21] Gain divided by 16384 then multiplied
// [R22] Calibration completion flag visible to software
module adc_filter_cal
  import adc_cal_pkg::*;
#(
  parameter int          NUM_CH         = 3,
  parameter logic [15:0] OFFSET_FACTORY = 16'h0000,
  parameter logic [15:0] GAIN_FACTORY   = GAIN_NOMINAL
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        filter_valid,
  input  wire logic [23:0] filter_data,
  output logic             chop_en,
  output logic             running_avg_en,
  output logic             sinc_modify_en,
  output logic      [6:0]  decimation_factor,
  output logic      [5:0]  averaging_factor,
  output logic             lp_mode,
  output logic             mod_clk_tick,
  output logic      [1:0]  cal_src_sel,
  output logic             conv_active,
  output logic      [15:0] result_data,
  output logic             result_valid
);
  if (NUM_CH < 1 || NUM_CH > MAX_CH) begin : g_bad_ch
    $error("NUM_CH out of range");
  end

  typedef enum logic [1:0] {
    st_off  = 2'b00,
    st_run  = 2'b01,
    st_cal1 = 2'b10,
    st_cal2 = 2'b11
  } conv_state_e;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic [3:0] coeff_decode(input logic [7:0] a);
    logic hit;
    hit = (a[CH_LSB-1:0] == 2'h0) && ({1'b0, a[CH_LSB+CH_W-1:CH_LSB]} < 3'(NUM_CH)) &&
          (((a & BANK_MASK) == OFFSET_BASE) || ((a & BANK_MASK) == GAIN_BASE));
    return {hit, (a & BANK_MASK) == GAIN_BASE, a[CH_LSB+CH_W-1:CH_LSB]};
  endfunction

  coeff_if cif ();

  conv_state_e       state_reg, state_next;
  logic [15:0]       filter_reg, filter_next;
  logic [MODE_W-1:0] mode_reg, mode_next;
  logic [1:0]        cnt_reg, cnt_next;
  logic              pair_reg, pair_next;
  logic [23:0]       first_reg, first_next;
  logic [15:0]       zero_reg, zero_next;
  logic [15:0]       result_reg, result_next;
  logic              rv_reg, rv_next;
  logic              done_reg, done_next;
  logic [31:0]       rdw_reg, rdw_next;
  logic              rdmem_reg, rdmem_next;
  logic [DIV_W-1:0]  div_reg, div_next;
  logic              tick_reg, tick_next;

  conv_mode_e cur_mode;
  logic [3:0] dec;
  logic       setup, access, wr, known, refuse, sw_coeff_wr, mode_wr;
  logic       emit, cal_fin, is_gain, is_self;
  logic [1:0] passes;

  assign cur_mode    = conv_mode_e'(mode_reg[MODE_HI:0]);
  assign dec         = coeff_decode(paddr);
  assign setup       = psel && !penable;
  assign access      = psel && penable;
  assign known       = dec[3] || paddr == FILTER_OFS || paddr == MODE_OFS ||
                       paddr == STATUS_OFS || paddr == RESULT_OFS;
  assign refuse      = dec[3] && pwrite && cur_mode != md_idle; // [R09]
  assign wr          = access && pwrite && known && !refuse;
  assign sw_coeff_wr = wr && dec[3];
  assign mode_wr     = wr && paddr == MODE_OFS;
  assign pready      = 1'b1;
  assign pslverr     = access && (!known || refuse);
  assign prdata      = rdmem_reg ? {16'h0000, cif.bus_rdata} : rdw_reg;

  // ----------------------------------------------------------------
  // Result datapath
  // ----------------------------------------------------------------
  logic signed [24:0]       sum_s;
  logic signed [23:0]       samp_s;
  logic signed [24:0]       corr_s;
  logic signed [PROD_W-1:0] prod_s, rnd_s;
  logic signed [16:0]       span_s;
  logic [31:0]              quot;
  logic [15:0]              code, meas16, gain_calc;

  always_comb begin
    sum_s  = $signed({first_reg[23], first_reg}) + $signed({filter_data[23], filter_data});
    // Chopped pairs are averaged; the sum keeps a guard bit against overflow [R07]
    samp_s = chop_en ? sum_s[24:1] : $signed(filter_data);
    // Offset spans +/-1.0 like the filter output, so it aligns to the top bits [R20]
    corr_s = $signed({samp_s[23], samp_s}) - $signed({cif.cur_off[15], cif.cur_off, 8'h00});
    prod_s = corr_s * $signed({1'b0, cif.cur_gain});
    rnd_s  = ((prod_s >>> GAIN_FRAC) + ROUND_HALF) >>> ROUND_BITS; // [R21]
    if (rnd_s > POS_LIM) begin
      code = POS_FS; // [R07]
    end else if (rnd_s < NEG_LIM) begin
      code = NEG_FS;
    end else begin
      code = rnd_s[15:0];
    end
    if (mode_reg[OFFBIN_BIT]) begin
      code[15] = ~code[15];
    end
    meas16 = samp_s[23:8];
    span_s = $signed({meas16[15], meas16}) - $signed({zero_reg[15], zero_reg});
    quot   = (span_s > 17'sh0_0000) ? GAIN_CAL_NUM / {15'h0000, span_s} : 32'h0000_0000;
    // Spans too small for the coefficient saturate it [R18]
    gain_calc = (span_s <= 17'sh0_0000 || quot > {16'h0000, GAIN_MAX}) ? GAIN_MAX : quot[15:0];
  end

  assign passes  = chop_en ? CAL_PASSES_CHOP : CAL_PASSES_PLAIN; // [R13]
  assign is_gain = mode_reg[0];
  assign is_self = !mode_reg[1];
  assign emit    = state_reg == st_run && filter_valid && (!chop_en || pair_reg);
  assign cal_fin = state_reg[1] && filter_valid && cnt_reg == passes - 2'h1;

  // ----------------------------------------------------------------
  // Control
  // ----------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    filter_next = filter_reg;
    mode_next   = mode_reg;
    cnt_next    = cnt_reg;
    pair_next   = pair_reg;
    first_next  = first_reg;
    zero_next   = zero_reg;
    result_next = result_reg;
    rv_next     = 1'b0;
    done_next   = done_reg;
    rdw_next    = rdw_reg;
    rdmem_next  = rdmem_reg;
    cif.wr_en   = sw_coeff_wr;
    cif.wr_gain = dec[2];
    cif.wr_ch   = dec[1:0];
    cif.wr_data = pwdata[15:0];
    if (filter_valid && state_reg != st_off) begin
      pair_next  = chop_en && !pair_reg;
      first_next = filter_data;
    end
    if (state_reg[1] && filter_valid) begin
      cnt_next = cnt_reg + 2'h1;
    end
    if (wr && paddr == FILTER_OFS) begin
      filter_next = pwdata[15:0]; // [R01]
    end
    if (wr && paddr == STATUS_OFS && pwdata[ST_DONE_BIT]) begin
      done_next = 1'b0;
    end
    if (mode_wr) begin
      // A new command aborts whatever was running [R15]
      mode_next = pwdata[MODE_W-1:0];
      cnt_next  = 2'h0;
      pair_next = 1'b0;
      unique case (conv_mode_e'(pwdata[MODE_HI:0]))
        md_off, md_idle:   state_next = st_off;
        md_cont, md_single: state_next = st_run;
        default:           state_next = st_cal1;
      endcase
    end else if (emit) begin
      result_next = code;
      rv_next     = 1'b1;
      if (cur_mode == md_single) begin
        mode_next[MODE_HI:0] = md_idle;
        state_next           = st_off;
      end
    end else if (cal_fin) begin
      cnt_next = 2'h0;
      if (state_reg == st_cal1 && is_gain) begin
        // First gain stage fixes the zero reference [R14]
        zero_next  = is_self ? meas16 : cif.cur_off; // [R19]
        state_next = st_cal2;
      end else begin
        cif.wr_en            = 1'b1; // [R10]
        cif.wr_gain          = is_gain;
        cif.wr_ch            = mode_reg[CH_HI:CH_LO];
        cif.wr_data          = is_gain ? gain_calc : meas16;
        mode_next[MODE_HI:0] = md_idle; // [R15]
        state_next           = st_off;
        done_next            = 1'b1; // [R22]
      end
    end
    if (setup) begin
      rdmem_next = dec[3];
      rdw_next   = 32'h0000_0000;
      if (paddr == FILTER_OFS) rdw_next = {16'h0000, filter_reg};
      if (paddr == MODE_OFS) rdw_next = {22'h00_0000, mode_reg};
      if (paddr == RESULT_OFS) rdw_next = {16'h0000, result_reg};
      if (paddr == STATUS_OFS) begin
        rdw_next[ST_DONE_BIT] = done_reg;
        rdw_next[ST_CAL_BIT]  = state_reg[1];
        rdw_next[ST_ACT_BIT]  = state_reg != st_off;
      end
    end
  end

  // Modulator clock enable; low power slows it about four times [R03]
  always_comb begin
    div_next  = 9'h000;
    tick_next = 1'b0;
    if (state_reg != st_off) begin
      if (div_reg == (mode_reg[LP_BIT] ? MOD_DIV_LOWPWR : MOD_DIV_NORMAL) - 9'h001) begin
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg  <= st_off;
      filter_reg <= FILTER_RESET;
      mode_reg   <= MODE_RESET;
      cnt_reg    <= 2'h0;
      pair_reg   <= 1'b0;
      first_reg  <= 24'h00_0000;
      zero_reg   <= 16'h0000;
      result_reg <= 16'h0000;
      rv_reg     <= 1'b0;
      done_reg   <= 1'b0;
      rdw_reg    <= 32'h0000_0000;
      rdmem_reg  <= 1'b0;
      div_reg    <= 9'h000;
      tick_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      filter_reg <= filter_next;
      mode_reg   <= mode_next;
      cnt_reg    <= cnt_next;
      pair_reg   <= pair_next;
      first_reg  <= first_next;
      zero_reg   <= zero_next;
      result_reg <= result_next;
      rv_reg     <= rv_next;
      done_reg   <= done_next;
      rdw_reg    <= rdw_next;
      rdmem_reg  <= rdmem_next;
      div_reg    <= div_next;
      tick_reg   <= tick_next;
    end
  end

  assign cif.bus_ch   = dec[1:0];
  assign cif.bus_gain = dec[2];
  assign cif.cur_ch   = mode_reg[CH_HI:CH_LO];

  coeff_store #(
    .NUM_CH         (NUM_CH),
    .OFFSET_FACTORY (OFFSET_FACTORY),
    .GAIN_FACTORY   (GAIN_FACTORY)
  ) u_store (
    .sys_clk (sys_clk),
    .rst     (rst),
    .cif     (cif.store)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fields go straight to the decimator, which sets the rates [R02] [R04] [R05]
  assign chop_en           = filter_reg[CHOP_BIT];
  assign running_avg_en    = filter_reg[RUNAVG_BIT];
  assign sinc_modify_en    = filter_reg[MODIFY_BIT];
  assign decimation_factor = filter_reg[SF_HI:SF_LO];
  assign averaging_factor  = filter_reg[AF_HI:AF_LO];
  assign lp_mode           = mode_reg[LP_BIT];
  assign mod_clk_tick      = tick_reg;
  assign conv_active       = state_reg != st_off;
  assign result_data       = result_reg;
  assign result_valid      = rv_reg;
  // Self modes pick internal references; system modes leave the pins [R11]
  assign cal_src_sel = !state_reg[1] || !is_self ? src_ext :
                       (state_reg == st_cal2 ? src_full : (is_gain ? src_zero : src_zero));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  filter_field_a: assert property (wr && paddr == FILTER_OFS |=> // [R01]
    decimation_factor == $past(pwdata[6:0]) && averaging_factor == $past(pwdata[13:8]))
    else $error("filter fields not loaded");
  mod_tick_gap_a: assert property (mod_clk_tick && conv_active |=> !mod_clk_tick[*8]) // [R03]
    else $error("modulator tick too fast");
  coeff_guard_a: assert property (access && pwrite && dec[3] && cur_mode != md_idle |-> // [R09]
    pslverr && !cif.wr_en || cal_fin) else $error("coefficient write outside idle");
  cal_abort_a: assert property (mode_wr && pwdata[MODE_HI] |=> state_reg == st_cal1 && // [R15]
    !result_valid) else $error("calibration did not abort conversion");
  cal_end_idle_a: assert property (cal_fin && !mode_wr && !(state_reg == st_cal1 && is_gain) |=> // [R15]
    cur_mode == md_idle && !conv_active && done_reg) else $error("calibration not ended in idle");
  gain_stage_a: assert property (cal_fin && !mode_wr && state_reg == st_cal1 && is_gain |=> // [R14]
    state_reg == st_cal2 && cnt_reg == 2'h0) else $error("gain stage two missing");
  cal_write_a: assert property (cal_fin && !mode_wr && state_reg == st_cal2 |-> // [R10]
    cif.wr_en && cif.wr_gain && cif.wr_data == gain_calc) else $error("gain not stored");
  self_src_a: assert property (state_reg == st_cal2 && is_self |-> cal_src_sel == src_full) // [R11]
    else $error("wrong calibration source");
  clamp_a: assert property (emit && !mode_wr && rnd_s > POS_LIM && !mode_reg[OFFBIN_BIT] |=> // [R07]
    result_valid && result_data == POS_FS) else $error("positive clamp missing");
  chop_pair_a: assert property (state_reg == st_run && chop_en && filter_valid && !pair_reg && // [R07]
    !mode_wr |=> !result_valid) else $error("chop result not averaged");
  done_hold_a: assert property (done_reg && !(wr && paddr == STATUS_OFS) |=> done_reg) // [R22]
    else $error("done flag lost");
  offset_cnt_a: assert property (state_reg[1] && filter_valid && !cal_fin && !mode_wr |=> // [R13]
    state_reg == $past(state_reg) && cnt_reg == $past(cnt_reg) + 2'h1)
    else $error("calibration stage ended early");

  self_off_c: cover property (cal_fin && cur_mode == md_self_off);
  gain_done_c: cover property (cal_fin && state_reg == st_cal2);
  clamp_c: cover property (emit && rnd_s > POS_LIM);
endmodule // adc_filter_cal

/* File: adc_front_model.sv */
// Behavioural decimator and analog front end feeding the filter link.
// Assumes the bench pulses fire for one cycle per wanted sample.
`timescale 1ns/10ps
module adc_front_model
  import adc_cal_pkg::*;
#(
  parameter logic [23:0] ZERO_RAW = 24'h00_3456,
  parameter logic [23:0] FULL_RAW = 24'h60_0000
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        fire,
  input  wire logic [1:0]  cal_src_sel,
  input  wire logic [23:0] ext_level,
  output logic             filter_valid,
  output logic      [23:0] filter_data
);
  // ----------------------------------------------------------------
  // Sample source
  // ----------------------------------------------------------------
  logic [23:0] src;
  always_comb begin
    case (cal_src_sel)
      2'h1:    src = ZERO_RAW;
      2'h2:    src = FULL_RAW;
      default: src = ext_level; // Bench holds it for the whole cycle
    endcase
  end
  // Data toggles off the strobe so a late capture shows
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      filter_valid <= 1'b0;
      filter_data  <= 24'h00_0000;
    end else begin
      filter_valid <= fire;
      filter_data  <= fire ? src : ~filter_data;
    end
  end
endmodule // adc_front_model

/* File: coeff_if.sv */
// Coefficient store port between control and storage.
// Assumes both ends run on sys_clk.
`timescale 1ns/10ps
interface coeff_if
  import adc_cal_pkg::*;
;
  logic            wr_en;
  logic            wr_gain;
  logic [CH_W-1:0] wr_ch;
  logic [15:0]     wr_data;
  logic [CH_W-1:0] bus_ch;
  logic            bus_gain;
  logic [15:0]     bus_rdata;
  logic [CH_W-1:0] cur_ch;
  logic [15:0]     cur_off;
  logic [15:0]     cur_gain;

  modport ctrl (output wr_en, wr_gain, wr_ch, wr_data, bus_ch, bus_gain, cur_ch,
                input  bus_rdata, cur_off, cur_gain);
  modport store (input  wr_en, wr_gain, wr_ch, wr_data, bus_ch, bus_gain, cur_ch,
                 output bus_rdata, cur_off, cur_gain);
endinterface // coeff_if

/* File: coeff_store.sv */
// Per-channel offset and gain coefficients with registered reads.
// Assumes the controller keeps software and calibration writes apart.
`timescale 1ns/10ps
module coeff_store
  import adc_cal_pkg::*;
#(
  parameter int          NUM_CH         = 3,
  parameter logic [15:0] OFFSET_FACTORY = 16'h0000,
  parameter logic [15:0] GAIN_FACTORY   = GAIN_NOMINAL
) (
  input wire logic sys_clk,
  input wire logic rst,
  coeff_if.store   cif
);
  logic [15:0] off_reg  [NUM_CH];
  logic [15:0] off_next [NUM_CH];
  logic [15:0] gain_reg  [NUM_CH];
  logic [15:0] gain_next [NUM_CH];
  logic [15:0] rd_reg, rd_next;
  logic [15:0] coff_reg, coff_next;
  logic [15:0] cgain_reg, cgain_next;

  always_comb begin
    off_next   = off_reg;
    gain_next  = gain_reg;
    rd_next    = 16'h0000;
    coff_next  = 16'h0000;
    cgain_next = 16'h0000;
    if (cif.wr_en && ({1'b0, cif.wr_ch} < 3'(NUM_CH))) begin
      if (cif.wr_gain) begin
        gain_next[cif.wr_ch] = cif.wr_data;
      end else begin
        off_next[cif.wr_ch] = cif.wr_data;
      end
    end
    if ({1'b0, cif.bus_ch} < 3'(NUM_CH)) begin
      rd_next = cif.bus_gain ? gain_reg[cif.bus_ch] : off_reg[cif.bus_ch];
    end
    if ({1'b0, cif.cur_ch} < 3'(NUM_CH)) begin
      coff_next  = off_reg[cif.cur_ch];
      cgain_next = gain_reg[cif.cur_ch];
    end
  end

  // Factory values come back on every reset [R08]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        off_reg[i]  <= OFFSET_FACTORY;
        gain_reg[i] <= GAIN_FACTORY;
      end
      rd_reg    <= 16'h0000;
      coff_reg  <= 16'h0000;
      cgain_reg <= 16'h0000;
    end else begin
      off_reg   <= off_next;
      gain_reg  <= gain_next;
      rd_reg    <= rd_next;
      coff_reg  <= coff_next;
      cgain_reg <= cgain_next;
    end
  end

  assign cif.bus_rdata = rd_reg;
  assign cif.cur_off   = coff_reg;
  assign cif.cur_gain  = cgain_reg;
endmodule // coeff_store
